// [design/bla_consts.vh]
// Constants for the byte, bit and literal datapath of the 8-bit core
`ifndef BLA_CONSTS_VH
`define BLA_CONSTS_VH

// ----------------------------------------
// Instruction cycle timing
// ----------------------------------------
`define BLA_OSC_PER_CYCLE 4
`define BLA_PHASE_W 2
`define BLA_PHASE_LAST 2'h3
`define BLA_SKIP_CYCLES 2

// ----------------------------------------
// Word layout
// ----------------------------------------
`define BLA_INSTR_W 14
`define BLA_DATA_W 8
`define BLA_ADDR_W 7
`define BLA_FILE_DEPTH 128
`define BLA_F_MSB 6
`define BLA_D_BIT 7
`define BLA_B_LSB 7
`define BLA_B_MSB 9

// ----------------------------------------
// Opcode patterns, compared on the top bits
// ----------------------------------------
`define BLA_OP6_ADD_WF 6'h07
`define BLA_OP6_AND_WF 6'h05
`define BLA_OP6_ZERO_F 6'h01
`define BLA_OP4_BIT_CLR 4'h4
`define BLA_OP4_BIT_SET 4'h5
`define BLA_OP4_BIT_TST 4'h7
`define BLA_OP5_ADD_IMM 5'h1F
`define BLA_OP6_AND_IMM 6'h39

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BLA_WORK_RST 8'h00
`define BLA_ZERO_BYTE 8'h00

`endif

// [design/bla_add8.v]
// Eight-bit adder with carry out of bit 7 and bit 3
`timescale 1ns/100ps
module bla_add8 (
    // Operands
    input wire [7:0] a_in,
    input wire [7:0] b_in,
    // Results
    output wire [7:0] sum_out,
    output wire carry_out,
    output wire digit_carry_out
);

    wire [8:0] full_sum;
    wire [4:0] low_sum;

    // Full sum and low nibble sum
    assign full_sum = {1'b0, a_in} + {1'b0, b_in};
    assign low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};

    // Flags from the two carry points
    assign sum_out = full_sum[7:0];
    assign carry_out = full_sum[8];
    assign digit_carry_out = low_sum[4];

endmodule // bla_add8

// [design/bla_alu.v]
// Execution datapath for byte, bit and literal instructions of an 8-bit core
// Function
// - Add-immediate adds an 8-bit literal to the work register and updates carry, digit carry and zero.
// - Add-work-and-file adds the work register to file register f and updates carry, digit carry and zero.
// - And-work-with-file ANDs the work register with file register f and updates only zero.
// - For the two file arithmetic/logic ops, d=0 writes the work register and d=1 writes file register f.
// - And-immediate ANDs the work register with a literal into the work register and updates only zero.
// - Clear-file-bit forces bit b of file register f to 0 and touches no flag.
// - Set-file-bit forces bit b of file register f to 1 and touches no flag.
// - Test-bit-skip runs the next instruction if bit b is 0, else replaces it by a no-op, flags untouched.
// - Zero-file-register writes 00h to file register f and sets zero.
// - Each instruction takes one cycle of four clocks, plus a no-op cycle when a skip is taken.
`timescale 1ns/100ps
`include "bla_consts.vh"
module bla_alu (
    // Clock and reset
    input wire SYS_CLK,
    input wire RST_N,
    // Instruction in, held for the whole instruction cycle
    input wire INSTR_VALID,
    input wire [13:0] INSTR_WORD,
    // File register loader and viewer
    input wire FILE_LOAD_EN,
    input wire [6:0] FILE_LOAD_ADDR,
    input wire [7:0] FILE_LOAD_DATA,
    input wire [6:0] FILE_VIEW_ADDR,
    output reg [7:0] FILE_VIEW_DATA,
    // Architectural state
    output reg [7:0] WORK_REG,
    output reg CARRY_FLAG,
    output reg DIGIT_CARRY_FLAG,
    output reg ZERO_FLAG,
    // Cycle status
    output wire CYCLE_END,
    output reg INSTR_DONE,
    output reg INSTR_DISCARDED,
    output reg INSTR_UNKNOWN,
    output reg SKIP_PENDING
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // One-hot mask for a bit position, shared by set and clear
    function [7:0] bit_mask;
        input [2:0] pos;
        begin
            bit_mask = 8'h01 << pos;
        end
    endfunction

    // Zero detect used by every flag-writing op
    function is_zero;
        input [7:0] val;
        begin
            is_zero = (val == `BLA_ZERO_BYTE);
        end
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [7:0] file_mem [0:`BLA_FILE_DEPTH-1];
    reg [1:0] phase_reg;
    reg skip_reg;

    // ----------------------------------------
    // Instruction cycle divider
    // ----------------------------------------

    // Four clocks make one instruction cycle; work happens on the last
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign CYCLE_END = (phase_reg == `BLA_PHASE_LAST);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [6:0] f_addr = INSTR_WORD[`BLA_F_MSB:0];
    wire dest_file = INSTR_WORD[`BLA_D_BIT];
    wire [2:0] bit_pos = INSTR_WORD[`BLA_B_MSB:`BLA_B_LSB];
    wire [7:0] imm = INSTR_WORD[7:0];
    wire [7:0] f_val = file_mem[f_addr];

    wire op_add_wf = (INSTR_WORD[13:8] == `BLA_OP6_ADD_WF);
    wire op_and_wf = (INSTR_WORD[13:8] == `BLA_OP6_AND_WF);
    wire op_zero_f = (INSTR_WORD[13:8] == `BLA_OP6_ZERO_F) && dest_file;
    wire op_bclr = (INSTR_WORD[13:10] == `BLA_OP4_BIT_CLR);
    wire op_bset = (INSTR_WORD[13:10] == `BLA_OP4_BIT_SET);
    wire op_btst = (INSTR_WORD[13:10] == `BLA_OP4_BIT_TST);
    wire op_add_imm = (INSTR_WORD[13:9] == `BLA_OP5_ADD_IMM);
    wire op_and_imm = (INSTR_WORD[13:8] == `BLA_OP6_AND_IMM);
    wire op_known = op_add_wf | op_and_wf | op_zero_f | op_bclr | op_bset | op_btst | op_add_imm | op_and_imm;

    // A held skip turns this cycle's instruction into a no-op
    wire exec = CYCLE_END && INSTR_VALID && !skip_reg;

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    wire [7:0] add_b = op_add_imm ? imm : f_val;
    wire [7:0] add_sum;
    wire add_c;
    wire add_dc;

    // Shared adder for both add forms
    bla_add8 u_add (
        .a_in(WORK_REG),
        .b_in(add_b),
        .sum_out(add_sum),
        .carry_out(add_c),
        .digit_carry_out(add_dc)
    );

    // ----------------------------------------
    // Result selection
    // ----------------------------------------
    reg [7:0] result;
    reg wr_work;
    reg wr_file;
    reg upd_z;
    reg upd_cdc;
    reg skip_next;

    // One result bus; write enables decide where it lands
    always @* begin
        result = `BLA_ZERO_BYTE;
        wr_work = 1'b0;
        wr_file = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        skip_next = 1'b0;
        if (op_add_imm) begin
            result = add_sum;
            wr_work = 1'b1;
            upd_z = 1'b1;
            upd_cdc = 1'b1;
        end else if (op_add_wf) begin
            result = add_sum;
            wr_work = !dest_file;
            wr_file = dest_file;
            upd_z = 1'b1;
            upd_cdc = 1'b1;
        end else if (op_and_wf) begin
            result = WORK_REG & f_val;
            wr_work = !dest_file;
            wr_file = dest_file;
            upd_z = 1'b1;
        end else if (op_and_imm) begin
            result = WORK_REG & imm;
            wr_work = 1'b1;
            upd_z = 1'b1;
        end else if (op_bclr) begin
            result = f_val & ~bit_mask(bit_pos);
            wr_file = 1'b1;
        end else if (op_bset) begin
            result = f_val | bit_mask(bit_pos);
            wr_file = 1'b1;
        end else if (op_btst) begin
            skip_next = f_val[bit_pos];
        end else if (op_zero_f) begin
            result = `BLA_ZERO_BYTE;
            wr_file = 1'b1;
            upd_z = 1'b1;
        end
    end

    // ----------------------------------------
    // Work register and flags
    // ----------------------------------------

    // Flags change only for the ops that own them
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WORK_REG <= `BLA_WORK_RST;
            CARRY_FLAG <= 1'b0;
            DIGIT_CARRY_FLAG <= 1'b0;
            ZERO_FLAG <= 1'b0;
        end else if (exec) begin
            if (wr_work) begin
                WORK_REG <= result;
            end
            if (upd_z) begin
                ZERO_FLAG <= is_zero(result);
            end
            if (upd_cdc) begin
                CARRY_FLAG <= add_c;
                DIGIT_CARRY_FLAG <= add_dc;
            end
        end
    end

    // ----------------------------------------
    // File registers
    // ----------------------------------------

    // Core write wins over the loader, which only seeds test data
    always @(posedge SYS_CLK) begin
        if (exec && wr_file) begin
            file_mem[f_addr] <= result;
        end else if (FILE_LOAD_EN) begin
            file_mem[FILE_LOAD_ADDR] <= FILE_LOAD_DATA;
        end
    end

    // Viewer is registered; array has no reset, so read it loaded
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            FILE_VIEW_DATA <= `BLA_ZERO_BYTE;
        end else begin
            FILE_VIEW_DATA <= file_mem[FILE_VIEW_ADDR];
        end
    end

    // ----------------------------------------
    // Skip and cycle status
    // ----------------------------------------

    // A taken skip spends the next instruction cycle as a no-op
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            skip_reg <= 1'b0;
            INSTR_DONE <= 1'b0;
            INSTR_DISCARDED <= 1'b0;
            INSTR_UNKNOWN <= 1'b0;
        end else begin
            INSTR_DONE <= exec;
            INSTR_DISCARDED <= CYCLE_END && skip_reg;
            INSTR_UNKNOWN <= exec && !op_known;
            if (CYCLE_END) begin
                skip_reg <= exec && skip_next;
            end
        end
    end

    always @* begin
        SKIP_PENDING = skip_reg;
    end

endmodule // bla_alu

// [bench/bla_alu_properties.sv]
// Checker for the byte, bit and literal datapath
`timescale 1ns/100ps
module bla_alu_props (
    // Clock and reset
    input wire SYS_CLK,
    input wire RST_N,
    // Instruction
    input wire INSTR_VALID,
    input wire [13:0] INSTR_WORD,
    // State and status
    input wire [7:0] WORK_REG,
    input wire CARRY_FLAG,
    input wire DIGIT_CARRY_FLAG,
    input wire ZERO_FLAG,
    input wire CYCLE_END,
    input wire INSTR_DONE,
    input wire INSTR_DISCARDED,
    input wire SKIP_PENDING,
    input wire INSTR_UNKNOWN
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Taken instruction, its literal and the flags
    wire tk = CYCLE_END && INSTR_VALID && !SKIP_PENDING;
    wire [7:0] k = INSTR_WORD[7:0];
    wire [2:0] fl = {CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG};
    // ----------
    // Properties
    // ----------
    property p_period; CYCLE_END |=> !CYCLE_END [*3] ##1 CYCLE_END; endproperty
    a_period: assert property (p_period) else $error("cycle length wrong");
    property p_idle; !CYCLE_END |=> $stable(WORK_REG) && $stable(fl); endproperty
    a_idle: assert property (p_idle) else $error("state moved mid cycle");
    property p_done; INSTR_DONE |-> $past(tk); endproperty
    a_done: assert property (p_done) else $error("done without taken word");
    property p_addi; tk && INSTR_WORD[13:9] == 5'h1F |=> {CARRY_FLAG, WORK_REG} == $past(WORK_REG) + $past({1'b0, k})
        && DIGIT_CARRY_FLAG == ($past(WORK_REG[3:0]) + $past({1'b0, k[3:0]}) > 5'd15)
        && ZERO_FLAG == (WORK_REG == 8'h00);
    endproperty
    a_addi: assert property (p_addi) else $error("add immediate wrong");
    property p_andi; tk && INSTR_WORD[13:8] == 6'h39 |=> WORK_REG == ($past(WORK_REG) & $past(k))
        && ZERO_FLAG == (WORK_REG == 8'h00) && fl[2:1] == $past(fl[2:1]); endproperty
    a_andi: assert property (p_andi) else $error("and immediate wrong");
    property p_bit; tk && INSTR_WORD[13:11] == 3'b010 |=> $stable(WORK_REG) && $stable(fl); endproperty
    a_bit: assert property (p_bit) else $error("bit op touched state");
    property p_skip; SKIP_PENDING && CYCLE_END && INSTR_VALID |=> INSTR_DISCARDED && !INSTR_DONE && !SKIP_PENDING
        && $stable(fl); endproperty
    a_skip: assert property (p_skip) else $error("skipped word not discarded");
    property p_zero_file_register; tk && INSTR_WORD[13:7] == 7'h03 |=> ZERO_FLAG && $stable(WORK_REG) && fl[2:1] == $past(fl[2:1]);
    endproperty
    a_zero_file_register: assert property (p_zero_file_register) else $error("clear file wrong");
    // An unhandled word spends its cycle and leaves all state alone
    property p_unk; INSTR_UNKNOWN |-> INSTR_DONE && $stable(WORK_REG) && $stable(fl); endproperty
    a_unk: assert property (p_unk) else $error("unknown word changed state");
    // Main scenarios reached
    c_add: cover property (tk && INSTR_WORD[13:9] == 5'h1F);
    c_skip: cover property (INSTR_DISCARDED);
    c_clr: cover property (tk && INSTR_WORD[13:7] == 7'h03);
endmodule // bla_alu_props
bind bla_alu bla_alu_props u_bla_alu_props (.SYS_CLK, .RST_N, .INSTR_VALID, .INSTR_WORD, .WORK_REG, .CARRY_FLAG,
    .DIGIT_CARRY_FLAG, .ZERO_FLAG, .CYCLE_END, .INSTR_DONE, .INSTR_DISCARDED, .SKIP_PENDING, .INSTR_UNKNOWN);

// [bench/tb_bla_alu.sv]
// Self-checking bench for the byte, bit and literal datapath
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; \
    if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_bla_alu;
    reg clk, rst_n, valid, ld_en;
    reg [13:0] word;
    reg [6:0] ld_a, vw_a;
    reg [7:0] ld_d;
    wire [7:0] vw_d, w;
    wire c, dc, z, ce, done, disc, sp, unk;
    integer fail_count = 0, checks_done = 0, i, j;
    reg got_done, got_disc, got_unk;
    bla_alu u_bla_alu (.SYS_CLK(clk), .RST_N(rst_n), .INSTR_VALID(valid), .INSTR_WORD(word), .FILE_LOAD_EN(ld_en),
        .FILE_LOAD_ADDR(ld_a), .FILE_LOAD_DATA(ld_d), .FILE_VIEW_ADDR(vw_a), .FILE_VIEW_DATA(vw_d), .WORK_REG(w),
        .CARRY_FLAG(c), .DIGIT_CARRY_FLAG(dc), .ZERO_FLAG(z), .CYCLE_END(ce), .INSTR_DONE(done),
        .INSTR_DISCARDED(disc), .INSTR_UNKNOWN(unk), .SKIP_PENDING(sp));
    // 25 MHz clock
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // -------------
    // Access tasks
    // -------------
    task end_of_test;
        begin
            $display("checks %0d errors %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task load(input [6:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {ld_en, ld_a, ld_d} = {1'b1, a, d};
            @(negedge clk);
            ld_en = 0;
        end
    endtask
    task fchk(input [6:0] a, input [7:0] e);
        begin
            @(negedge clk);
            vw_a = a;
            @(negedge clk);
            `CHK("file", e, vw_d)
        end
    endtask
    // Hold the word until the cycle end edge takes it; bounded wait
    task run(input [13:0] x);
        begin
            @(negedge clk);
            {valid, word} = {1'b1, x};
            for (i = 0; i < 8 && !ce; i = i + 1) @(negedge clk);
            if (ce !== 1'b1) begin
                fail_count++;
                end_of_test;
            end
            @(negedge clk);
            {got_done, got_disc, got_unk} = {done, disc, unk};
            valid = 0;
        end
    endtask
    task st(input [7:0] ew, input [2:0] ef);
        begin
            `CHK("work", ew, w)
            `CHK("flags", ef, {c, dc, z})
        end
    endtask
    // ---------
    // Sequence
    // ---------
    initial begin
        {rst_n, valid, word, ld_en, ld_a, ld_d, vw_a} = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        run(14'h3EFF);
        st(8'hFF, 3'b000);
        run(14'h3F01);
        st(8'h00, 3'b111);
        run(14'h39FF);
        st(8'h00, 3'b111);
        run(14'h3E5A);
        run(14'h390F);
        st(8'h0A, 3'b000);
        load(7'h7F, 8'h88);
        load(7'h00, 8'hE6);
        run(14'h07FF);
        st(8'h0A, 3'b010);
        fchk(7'h7F, 8'h92);
        run(14'h0700);
        st(8'hF0, 3'b010);
        fchk(7'h00, 8'hE6);
        run(14'h3E4C);
        st(8'h3C, 3'b100);
        run(14'h057F);
        st(8'h10, 3'b100);
        run(14'h0580);
        st(8'h10, 3'b101);
        fchk(7'h00, 8'h00);
        // Every bit position, cleared then set, neighbours kept
        for (j = 0; j < 8; j = j + 1) begin
            load(7'h05, 8'hFF);
            run({4'h4, j[2:0], 7'h05});
            fchk(7'h05, ~(8'h01 << j));
            run({4'h5, j[2:0], 7'h05});
            fchk(7'h05, 8'hFF);
        end
        // Clear tested bit runs the next word; set tested bit discards it
        load(7'h05, 8'h01);
        run(14'h1C85);
        run(14'h3E01);
        `CHK("done", 1'b1, got_done)
        `CHK("disc", 1'b0, got_disc)
        run(14'h1C05);
        `CHK("skip", 1'b1, sp)
        run(14'h3E01);
        `CHK("disc", 1'b1, got_disc)
        `CHK("done", 1'b0, got_done)
        st(8'h11, 3'b000);
        run(14'h0185);
        st(8'h11, 3'b001);
        fchk(7'h05, 8'h00);
        // Clear-work form is not handled here: flagged and spent as a no-op
        run(14'h0100);
        `CHK("unknown", 1'b1, got_unk)
        st(8'h11, 3'b001);
        end_of_test;
    end
endmodule // tb_bla_alu
